//--- logic/hcc_consts.svh
// register offsets, field positions, limits and timing counts for the hole-count cut controller
`ifndef HCC_CONSTS_SVH
`define HCC_CONSTS_SVH
`define HCC_OFS_CTRL 8'h00
`define HCC_OFS_CMD 8'h04
`define HCC_OFS_STAT 8'h08
`define HCC_OFS_QTY 8'h0c
`define HCC_OFS_HCNT 8'h10
`define HCC_OFS_OFFS 8'h14
`define HCC_OFS_PLEN 8'h18
`define HCC_OFS_SDET 8'h1c
`define HCC_OFS_SPAC 8'h20
`define HCC_OFS_NOHL 8'h24
`define HCC_OFS_MDIE 8'h28
`define HCC_OFS_JOB 8'h2c
`define HCC_OFS_QREM 8'h30
`define HCC_OFS_HPAS 8'h34
`define HCC_OFS_LPAS 8'h38
`define HCC_OFS_SPD 8'h3c
`define HCC_OFS_TPCS 8'h40
`define HCC_OFS_TLEN 8'h44
`define HCC_OFS_DTGT 8'h48
`define HCC_CTRL_COUNT 0
`define HCC_CTRL_REMOTE 1
`define HCC_CTRL_MULTI 2
`define HCC_CMD_CLEAR 0
`define HCC_CMD_YES 1
`define HCC_ST_RUN 0
`define HCC_ST_NOHOLE 1
`define HCC_ST_ABORT 2
`define HCC_ST_MCBUSY 3
`define HCC_QTY_MIN 14'h0001
`define HCC_QTY_MAX 14'h270e
`define HCC_QTY_FREE 14'h270f
`define HCC_HOLE_MAX 9'h1f4
`define HCC_HQ_DEPTH 16
`define HCC_HQ_AW 4
`define HCC_TQ_AW 2
`define HCC_SPEED_WIN_MS 100
`define HCC_CLK_MHZ 100
`define HCC_SPEED_WIN_CYC (`HCC_SPEED_WIN_MS * 1000 * `HCC_CLK_MHZ)
`endif

//--- logic/hcc_pkg.sv
// types shared by the hole-count cut controller
package hcc_pkg;
  // manual crop cut sequence, gray coded along the usual path
  typedef enum logic [1:0] {
    MC_IDLE = 2'b00,
    MC_JOG = 2'b01,
    MC_MOVE = 2'b11,
    MC_PRESS = 2'b10
  } hcc_mc_e;
  typedef logic [31:0] hcc_pos_t;
endpackage

//--- logic/hcc_top.sv
// hole-count cut controller with apb register access
`timescale 1ns/100ps
`include "hcc_consts.svh"
module hcc_top #(
  parameter int SPEED_WIN_CYC = `HCC_SPEED_WIN_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic enc_step,
  input wire logic hole_det,
  input wire logic run_key,
  input wire logic halt_key,
  input wire logic remote_run,
  input wire logic cycle_btn,
  input wire logic die_home,
  input wire logic die_at_target,
  input wire logic press_done,
  output logic line_run,
  output logic die_jog,
  output logic die_move,
  output logic press
);
  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic count_mode_r, remote_r, multi_r, run_r, nohole_r, abort_r;
  logic [13:0] qty_r, qrem_r;
  logic [8:0] hcnt_prog_r, hcnt_r;
  logic [9:0] job_r;
  hcc_pkg::hcc_pos_t offs_r, plen_r, sdet_r, spac_r, nohl_r, mdie_r;
  hcc_pkg::hcc_pos_t pos_r, last_cut_r, lock_end_r, tgt_r, tpcs_r, tlen_r;
  hcc_pkg::hcc_pos_t spd_r, spd_acc_r, fire_pos_r;
  logic [31:0] win_r;
  logic lock_r, auto_r;
  logic [2:0] det_sync_r;
  hcc_pkg::hcc_mc_e mc_r;
  logic [31:0] prdata_r;
  logic pready_r, pslverr_r;
  hcc_pkg::hcc_pos_t hq [`HCC_HQ_DEPTH];
  logic [`HCC_HQ_AW-1:0] hq_head_r, hq_tail_r;
  logic [`HCC_HQ_AW:0] hq_cnt_r;
  hcc_pkg::hcc_pos_t tq [4];
  logic [`HCC_TQ_AW-1:0] tq_head_r, tq_tail_r;
  logic [`HCC_TQ_AW:0] tq_cnt_r;

  // ------------------------------------------------------------
  // apb decode
  // ------------------------------------------------------------
  logic wr, setup, halted, clear, hole_ev, cycle_prev_r;
  assign setup = psel && !penable;
  assign wr = psel && penable && pready_r && pwrite;
  assign halted = !run_r;
  assign clear = wr && paddr == `HCC_OFS_CMD && halted && pwdata[`HCC_CMD_CLEAR]
    && pwdata[`HCC_CMD_YES];

  function automatic logic mapped(input logic [7:0] a);
    mapped = a[1:0] == 2'b00 && a <= `HCC_OFS_DTGT;
  endfunction

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r <= setup;
      pslverr_r <= setup && !mapped(paddr);
    end
  end

  // ------------------------------------------------------------
  // configuration writes
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_mode_r <= 1'b0;
      remote_r <= 1'b0;
      multi_r <= 1'b0;
      qty_r <= `HCC_QTY_MIN;
      hcnt_prog_r <= 9'h001;
      job_r <= 10'h000;
      offs_r <= 32'h0;
      plen_r <= 32'h0;
      sdet_r <= 32'h0;
      spac_r <= 32'h0;
      nohl_r <= 32'h0;
      mdie_r <= 32'h0;
    end else if (wr) begin
      unique case (paddr)
        `HCC_OFS_CTRL: begin
          if (halted) begin
            count_mode_r <= pwdata[`HCC_CTRL_COUNT];
            remote_r <= pwdata[`HCC_CTRL_REMOTE];
            multi_r <= pwdata[`HCC_CTRL_MULTI];
          end
        end
        `HCC_OFS_QTY: begin
          if (pwdata[13:0] >= `HCC_QTY_MIN && pwdata[13:0] <= `HCC_QTY_FREE
              && pwdata[31:14] == 18'h0) begin
            qty_r <= pwdata[13:0];
          end
        end
        `HCC_OFS_HCNT: begin
          if (pwdata[8:0] != 9'h0 && pwdata[8:0] <= `HCC_HOLE_MAX && pwdata[31:9] == 23'h0) begin
            hcnt_prog_r <= pwdata[8:0];
          end
        end
        `HCC_OFS_JOB: begin
          if (multi_r) begin
            job_r <= pwdata[9:0];
          end
        end
        `HCC_OFS_OFFS: offs_r <= pwdata;
        `HCC_OFS_PLEN: plen_r <= pwdata;
        `HCC_OFS_SDET: sdet_r <= pwdata;
        `HCC_OFS_SPAC: spac_r <= pwdata;
        `HCC_OFS_NOHL: nohl_r <= pwdata;
        `HCC_OFS_MDIE: mdie_r <= pwdata;
        default: ;
      endcase
    end
  end

  // ------------------------------------------------------------
  // position, detector and lockout
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      det_sync_r <= 3'b000;
      pos_r <= 32'h0;
      tlen_r <= 32'h0;
    end else begin
      det_sync_r <= {det_sync_r[1:0], hole_det};
      pos_r <= pos_r + {31'h0, enc_step};
      tlen_r <= tlen_r + {31'h0, enc_step};
    end
  end

  // one event per rising edge outside the lockout; first sync stage feeds only the second
  assign hole_ev = det_sync_r[1] && !det_sync_r[2] && !lock_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_r <= 1'b0;
      lock_end_r <= 32'h0;
    end else if (hole_ev && run_r) begin
      lock_r <= 1'b1;
      lock_end_r <= pos_r + spac_r;
    end else if (lock_r && pos_r >= lock_end_r) begin
      lock_r <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // hole queue and cut targets
  // ------------------------------------------------------------
  logic hq_pop, tq_push, tq_pop, fire;
  assign hq_pop = hq_cnt_r != 0 && hq[hq_head_r] + sdet_r <= last_cut_r;
  assign tq_push = hole_ev && hcnt_r + 9'h001 >= hcnt_prog_r;
  assign tq_pop = fire || (!count_mode_r && tq_cnt_r != 0 && tq[tq_head_r] <= pos_r);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hq_head_r <= '0;
      hq_tail_r <= '0;
      hq_cnt_r <= '0;
      hcnt_r <= 9'h0;
      tq_head_r <= '0;
      tq_tail_r <= '0;
      tq_cnt_r <= '0;
    end else if (clear) begin
      hq_head_r <= '0;
      hq_tail_r <= '0;
      hq_cnt_r <= '0;
      hcnt_r <= 9'h0;
      tq_head_r <= '0;
      tq_tail_r <= '0;
      tq_cnt_r <= '0;
    end else begin
      // a full ring drops its oldest hole
      if (hole_ev) begin
        hq_tail_r <= hq_tail_r + 1'b1;
      end
      if (hq_pop || (hole_ev && hq_cnt_r == `HCC_HQ_DEPTH)) begin
        hq_head_r <= hq_head_r + 1'b1;
      end
      if (hole_ev && !hq_pop && hq_cnt_r != `HCC_HQ_DEPTH) begin
        hq_cnt_r <= hq_cnt_r + 1'b1;
      end else if (hq_pop && !hole_ev) begin
        hq_cnt_r <= hq_cnt_r - 1'b1;
      end
      if (hole_ev) begin
        hcnt_r <= tq_push ? 9'h0 : hcnt_r + 9'h001;
      end
      if (tq_push) begin
        tq_tail_r <= tq_tail_r + 1'b1;
      end
      if (tq_pop) begin
        tq_head_r <= tq_head_r + 1'b1;
      end
      if (tq_push && !tq_pop) begin
        tq_cnt_r <= tq_cnt_r + 1'b1;
      end else if (tq_pop && !tq_push) begin
        tq_cnt_r <= tq_cnt_r - 1'b1;
      end
    end
  end

  // queue memories hold no control state, so they take no reset
  always_ff @(posedge pclk) begin
    if (hole_ev) begin
      hq[hq_tail_r] <= pos_r;
    end
    if (tq_push) begin
      tq[tq_tail_r] <= pos_r + sdet_r + offs_r;
    end
  end

  // holes past the shear and the nearest reachable hole for a crop cut
  logic [`HCC_HQ_AW:0] hpas;
  hcc_pkg::hcc_pos_t near_d, d;
  logic near_ok;
  logic [`HCC_HQ_AW-1:0] idx;
  always_comb begin
    hpas = '0;
    near_d = 32'h0;
    near_ok = 1'b0;
    d = 32'h0;
    idx = '0;
    for (int i = 0; i < `HCC_HQ_DEPTH; i++) begin
      idx = hq_head_r + i[`HCC_HQ_AW-1:0];
      d = pos_r - hq[idx] - sdet_r;
      if (i[`HCC_HQ_AW:0] < hq_cnt_r && hq[idx] + sdet_r <= pos_r) begin
        hpas = hpas + 1'b1;
        if (d >= mdie_r && (!near_ok || d < near_d)) begin
          near_ok = 1'b1;
          near_d = d;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // run control and automatic cuts
  // ------------------------------------------------------------
  logic start, stop, nohole;
  hcc_pkg::hcc_pos_t lpas;
  assign lpas = pos_r - last_cut_r;
  assign nohole = run_r && count_mode_r && nohl_r != 32'h0 && tq_cnt_r == 0
    && lpas + sdet_r > nohl_r;
  assign start = halted && mc_r == hcc_pkg::MC_IDLE && qrem_r != 14'h0
    && (remote_r ? remote_run : run_key);
  assign stop = halt_key || (remote_r && !remote_run) || nohole;
  assign fire = run_r && !press && !auto_r && (count_mode_r
    ? (tq_cnt_r != 0 && pos_r >= tq[tq_head_r]) : (lpas >= plen_r));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_r <= 1'b0;
      qrem_r <= `HCC_QTY_MIN;
      tpcs_r <= 32'h0;
      fire_pos_r <= 32'h0;
    end else begin
      if (start) begin
        run_r <= 1'b1;
      end else if (stop || (fire && qrem_r == 14'h1 && qty_r != `HCC_QTY_FREE)) begin
        run_r <= 1'b0;
      end
      if (wr && paddr == `HCC_OFS_QTY) begin
        qrem_r <= (pwdata[13:0] >= `HCC_QTY_MIN && pwdata[13:0] <= `HCC_QTY_FREE
          && pwdata[31:14] == 18'h0) ? pwdata[13:0] : qrem_r;
      end else if (fire && qty_r != `HCC_QTY_FREE) begin
        qrem_r <= qrem_r - 14'h1;
      end
      if (fire) begin
        tpcs_r <= tpcs_r + 32'h1;
        fire_pos_r <= pos_r;
      end
    end
  end

  // ------------------------------------------------------------
  // press and manual crop cut
  // ------------------------------------------------------------
  logic cyc_rise, held;
  assign cyc_rise = cycle_btn && !cycle_prev_r;
  assign held = cycle_btn;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mc_r <= hcc_pkg::MC_IDLE;
      auto_r <= 1'b0;
      press <= 1'b0;
      die_jog <= 1'b0;
      die_move <= 1'b0;
      tgt_r <= 32'h0;
      last_cut_r <= 32'h0;
      cycle_prev_r <= 1'b0;
    end else begin
      cycle_prev_r <= cycle_btn;
      if (fire) begin
        auto_r <= 1'b1;
        press <= 1'b1;
      end else if (auto_r && press_done) begin
        auto_r <= 1'b0;
        press <= 1'b0;
        last_cut_r <= fire_pos_r;
      end
      unique case (mc_r)
        hcc_pkg::MC_IDLE: begin
          // running blocks the manual cycle, except when the run starts in the same cycle as the button rise
          if (cyc_rise && halted && !auto_r) begin
            mc_r <= hcc_pkg::MC_JOG;
            die_jog <= 1'b1;
          end
        end
        hcc_pkg::MC_JOG: begin
          if (!held) begin
            mc_r <= hcc_pkg::MC_IDLE;
            die_jog <= 1'b0;
          end else if (die_home) begin
            mc_r <= hcc_pkg::MC_MOVE;
            die_jog <= 1'b0;
            die_move <= 1'b1;
            tgt_r <= near_ok ? near_d : mdie_r;
          end
        end
        hcc_pkg::MC_MOVE: begin
          if (!held) begin
            mc_r <= hcc_pkg::MC_IDLE;
            die_move <= 1'b0;
          end else if (die_at_target) begin
            mc_r <= hcc_pkg::MC_PRESS;
            die_move <= 1'b0;
            press <= 1'b1;
          end
        end
        hcc_pkg::MC_PRESS: begin
          if (!held) begin
            mc_r <= hcc_pkg::MC_IDLE;
            press <= 1'b0;
          end else if (press_done) begin
            mc_r <= hcc_pkg::MC_IDLE;
            press <= 1'b0;
            last_cut_r <= pos_r - tgt_r;
          end
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // error flags, set wins over write-one-to-clear
  // ------------------------------------------------------------
  logic abort_ev, stat_wr;
  assign abort_ev = mc_r != hcc_pkg::MC_IDLE && !held;
  assign stat_wr = wr && paddr == `HCC_OFS_STAT;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nohole_r <= 1'b0;
      abort_r <= 1'b0;
    end else begin
      nohole_r <= nohole || (nohole_r && !(stat_wr && pwdata[`HCC_ST_NOHOLE]));
      abort_r <= abort_ev || (abort_r && !(stat_wr && pwdata[`HCC_ST_ABORT]));
    end
  end

  // ------------------------------------------------------------
  // line speed: encoder steps per window
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      win_r <= 32'h0;
      spd_acc_r <= 32'h0;
      spd_r <= 32'h0;
    end else if (win_r == 32'(SPEED_WIN_CYC - 1)) begin
      win_r <= 32'h0;
      spd_r <= spd_acc_r + {31'h0, enc_step};
      spd_acc_r <= 32'h0;
    end else begin
      win_r <= win_r + 32'h1;
      spd_acc_r <= spd_acc_r + {31'h0, enc_step};
    end
  end

  // ------------------------------------------------------------
  // read mux, captured in the setup cycle
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0;
    end else if (setup) begin
      unique case (paddr)
        `HCC_OFS_CTRL: prdata_r <= {29'h0, multi_r, remote_r, count_mode_r};
        `HCC_OFS_STAT: prdata_r <= {28'h0, mc_r != hcc_pkg::MC_IDLE, abort_r, nohole_r, run_r};
        `HCC_OFS_QTY: prdata_r <= {18'h0, qty_r};
        `HCC_OFS_HCNT: prdata_r <= {23'h0, hcnt_prog_r};
        `HCC_OFS_OFFS: prdata_r <= offs_r;
        `HCC_OFS_PLEN: prdata_r <= plen_r;
        `HCC_OFS_SDET: prdata_r <= sdet_r;
        `HCC_OFS_SPAC: prdata_r <= spac_r;
        `HCC_OFS_NOHL: prdata_r <= nohl_r;
        `HCC_OFS_MDIE: prdata_r <= mdie_r;
        `HCC_OFS_JOB: prdata_r <= multi_r ? {22'h0, job_r} : 32'h0;
        `HCC_OFS_QREM: prdata_r <= {18'h0, qrem_r};
        `HCC_OFS_HPAS: prdata_r <= {27'h0, hpas};
        `HCC_OFS_LPAS: prdata_r <= lpas;
        `HCC_OFS_SPD: prdata_r <= spd_r;
        `HCC_OFS_TPCS: prdata_r <= tpcs_r;
        `HCC_OFS_TLEN: prdata_r <= tlen_r;
        `HCC_OFS_DTGT: prdata_r <= tgt_r;
        default: prdata_r <= 32'h0;
      endcase
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign line_run = run_r;
endmodule

//--- verif/hcc_assertions.sv
// port checker for the hole-count cut controller
`timescale 1ns/100ps
module hcc_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic run_key,
  input wire logic halt_key,
  input wire logic remote_run,
  input wire logic cycle_btn,
  input wire logic die_home,
  input wire logic die_at_target,
  input wire logic press_done,
  input wire logic line_run,
  input wire logic die_jog,
  input wire logic die_move,
  input wire logic press
);
  // ----------------
  // bus handshake, run control and manual cut steps
  // ----------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_home;
    die_jog && die_home && cycle_btn;
  endsequence
  sequence s_tgt;
    die_move && die_at_target && cycle_btn;
  endsequence
  a_ack_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ack_only: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  a_err_unmapped: assert property (psel && penable && (paddr > 8'h48 || paddr[1:0] != 2'b00)
    |-> pslverr) else $error("unmapped not refused");
  a_start_cause: assert property ($rose(line_run) |-> $past(run_key) || $past(remote_run))
    else $error("start without key");
  a_halt_stops: assert property (line_run && halt_key |=> !line_run)
    else $error("halt ignored");
  a_no_manual_run: assert property (line_run |-> !die_jog && !die_move)
    else $error("manual move while running");
  a_jog_cause: assert property ($rose(die_jog) |-> $past(cycle_btn) && !$past(line_run))
    else $error("jog without cycle button");
  a_home_move: assert property (s_home |=> die_move && !die_jog)
    else $error("no move after home");
  a_tgt_press: assert property (s_tgt |=> press && !die_move)
    else $error("no press at target");
  a_abort_drop: assert property (!cycle_btn && (die_jog || die_move) |=> !die_jog && !die_move)
    else $error("manual cut not aborted");
  a_press_end: assert property (press && press_done |=> !press)
    else $error("press held after done");
endmodule

bind hcc_top hcc_chk u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .paddr(paddr), .pready(pready), .pslverr(pslverr), .run_key(run_key),
  .halt_key(halt_key), .remote_run(remote_run), .cycle_btn(cycle_btn),
  .die_home(die_home), .die_at_target(die_at_target), .press_done(press_done),
  .line_run(line_run), .die_jog(die_jog), .die_move(die_move), .press(press)
);

//--- verif/hcc_plant.sv
// far-side model: encoder, hole detector, die switches and press
`timescale 1ns/100ps
module hcc_plant #(
  parameter int DIV = 8,
  parameter int GAP = 20
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic line_run,
  input wire logic die_jog,
  input wire logic die_move,
  input wire logic press,
  output logic enc_step,
  output logic hole_det,
  output logic die_home,
  output logic die_at_target,
  output logic press_done,
  output logic [31:0] pos
);
  int dv;
  int jc;
  int mc;
  int pc;
  int unsigned ph;
  // slow steps: position holds still across the detector sync delay
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dv <= 0;
      enc_step <= 1'b0;
      pos <= 32'h0;
    end else begin
      dv <= (dv == DIV - 1) ? 0 : dv + 1;
      enc_step <= (line_run || die_jog) && dv == DIV - 1;
      if ((line_run || die_jog) && dv == DIV - 1) begin
        pos <= pos + 32'h1;
      end
    end
  end
  // second pulse in each hole mimics its trailing edge seen again
  assign ph = pos % GAP;
  assign hole_det = (ph == 10 || ph == 11 || ph == 13 || ph == 14);
  assign die_home = jc >= 3;
  assign die_at_target = mc >= 3;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      jc <= 0;
      mc <= 0;
      pc <= 0;
      press_done <= 1'b0;
    end else begin
      jc <= die_jog ? jc + 1 : 0;
      mc <= die_move ? mc + 1 : 0;
      pc <= press ? pc + 1 : 0;
      press_done <= pc == 3;
    end
  end
endmodule

//--- verif/tb.sv
// self-checking bench for the hole-count cut controller
`timescale 1ns/100ps
`include "hcc_consts.svh"
module tb;
  typedef struct packed {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] x;} hcc_row_s;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdv, pos;
  logic enc_step, hole_det, run_key, halt_key, remote_run, cycle_btn, rerr;
  logic die_home, die_at_target, press_done, line_run, die_jog, die_move, press, press_q;
  int err_count, n_compared, cyc, n_fire, k;
  logic [31:0] fpos [16];
  hcc_row_s rows [12] = '{
    '{1'b1, `HCC_OFS_QTY, 32'h270e, 32'h270e}, '{1'b1, `HCC_OFS_QTY, 32'h0, 32'h270e},
    '{1'b1, `HCC_OFS_QTY, 32'h2710, 32'h270e}, '{1'b1, `HCC_OFS_QTY, 32'h270f, 32'h270f},
    '{1'b0, `HCC_OFS_QREM, 32'h0, 32'h270f}, '{1'b1, `HCC_OFS_QREM, 32'h5, 32'h270f},
    '{1'b1, `HCC_OFS_HCNT, 32'h1f4, 32'h1f4}, '{1'b1, `HCC_OFS_HCNT, 32'h1f5, 32'h1f4},
    '{1'b1, `HCC_OFS_JOB, 32'h5, 32'h0}, '{1'b1, `HCC_OFS_CTRL, 32'h4, 32'h4},
    '{1'b1, `HCC_OFS_JOB, 32'h5, 32'h5}, '{1'b1, `HCC_OFS_CTRL, 32'h0, 32'h0}};

  hcc_top #(.SPEED_WIN_CYC(16)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .enc_step(enc_step), .hole_det(hole_det), .run_key(run_key), .halt_key(halt_key),
    .remote_run(remote_run), .cycle_btn(cycle_btn), .die_home(die_home),
    .die_at_target(die_at_target), .press_done(press_done), .line_run(line_run),
    .die_jog(die_jog), .die_move(die_move), .press(press));
  hcc_plant plant (
    .pclk(pclk), .presetn(presetn), .line_run(line_run), .die_jog(die_jog),
    .die_move(die_move), .press(press), .enc_step(enc_step), .hole_det(hole_det),
    .die_home(die_home), .die_at_target(die_at_target), .press_done(press_done), .pos(pos));

  // -----
  // tasks
  // -----
  task automatic tally_and_finish;
    $display("mismatches %0d of %0d compared", err_count, n_compared);
    if (err_count == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_compared++;
    if (g !== x) begin
      err_count++;
      $display("BAD %0t got %h want %h", $time, g, x);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // only the bench timeout ends a wait for ready
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdv = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic kick;
    @(posedge pclk);
    run_key <= 1'b1;
    @(posedge pclk);
    run_key <= 1'b0;
  endtask

  // ---------------------
  // clock, timeout, press
  // ---------------------
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    press_q <= press;
    if (press === 1'b1 && press_q === 1'b0 && n_fire < 16) begin
      fpos[n_fire] = pos;
      n_fire++;
    end
    if (cyc > 20000) begin
      err_count++;
      tally_and_finish;
    end
  end

  initial begin
    {presetn, psel, penable, pwrite, run_key, halt_key, remote_run, cycle_btn} = 8'h00;
    press_q = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (6) @(posedge pclk);
    chk(32'(line_run | press | die_jog | die_move), 32'h0);
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    xfer(1'b0, `HCC_OFS_HCNT, 32'h0);
    chk(rdv, 32'h1);
    xfer(1'b0, 8'h4c, 32'h0);
    chk(32'(rerr), 32'h1);
    foreach (rows[i]) begin
      if (rows[i].w) xfer(1'b1, rows[i].a, rows[i].d);
      xfer(1'b0, rows[i].a, 32'h0);
      chk(rdv, rows[i].x);
    end
    // count mode, two holes a part, bounce inside each hole
    xfer(1'b1, `HCC_OFS_SDET, 32'h4);
    xfer(1'b1, `HCC_OFS_OFFS, 32'h3);
    xfer(1'b1, `HCC_OFS_SPAC, 32'h8);
    xfer(1'b1, `HCC_OFS_HCNT, 32'h2);
    xfer(1'b1, `HCC_OFS_QTY, 32'h3);
    xfer(1'b1, `HCC_OFS_CTRL, 32'h1);
    kick();
    wait (line_run === 1'b1);
    wait (line_run === 1'b0);
    wait (press === 1'b0);
    chk(n_fire, 3);
    for (int i = 0; i < 3; i++) chk(fpos[i], 37 + 40 * i);
    xfer(1'b0, `HCC_OFS_QREM, 32'h0);
    chk(rdv, 32'h0);
    xfer(1'b1, `HCC_OFS_QTY, `HCC_QTY_FREE);
    kick();
    wait (n_fire == 5);
    @(posedge pclk);
    halt_key <= 1'b1;
    @(posedge pclk);
    halt_key <= 1'b0;
    wait (line_run === 1'b0 && press === 1'b0);
    xfer(1'b0, `HCC_OFS_QREM, 32'h0);
    chk(rdv, 32'h270f);
    xfer(1'b0, `HCC_OFS_TPCS, 32'h0);
    chk(rdv, 32'h5);
    // remote: local key must not start, contact does
    xfer(1'b1, `HCC_OFS_CTRL, 32'h3);
    kick();
    repeat (3) @(posedge pclk);
    chk(32'(line_run), 32'h0);
    remote_run <= 1'b1;
    wait (line_run === 1'b1);
    xfer(1'b1, `HCC_OFS_CTRL, 32'h0);
    xfer(1'b0, `HCC_OFS_CTRL, 32'h0);
    chk(rdv, 32'h3);
    @(posedge pclk);
    cycle_btn <= 1'b1;
    repeat (4) @(posedge pclk);
    cycle_btn <= 1'b0;
    remote_run <= 1'b0;
    repeat (3) @(posedge pclk);
    chk(32'(line_run), 32'h0);
    xfer(1'b1, `HCC_OFS_CTRL, 32'h1);
    xfer(1'b1, `HCC_OFS_HCNT, 32'h1f4);
    xfer(1'b1, `HCC_OFS_NOHL, 32'h1e);
    kick();
    wait (line_run === 1'b1);
    wait (line_run === 1'b0);
    xfer(1'b0, `HCC_OFS_STAT, 32'h0);
    chk(32'(rdv[`HCC_ST_NOHOLE]), 32'h1);
    xfer(1'b1, `HCC_OFS_STAT, 32'h2);
    xfer(1'b1, `HCC_OFS_NOHL, 32'h0);
    // the only queued hole sits closer than this, so the crop lands here
    xfer(1'b1, `HCC_OFS_MDIE, 32'h20);
    // manual crop held through, then one released early
    @(posedge pclk);
    cycle_btn <= 1'b1;
    wait (press === 1'b1);
    wait (press === 1'b0);
    @(posedge pclk);
    cycle_btn <= 1'b0;
    xfer(1'b0, `HCC_OFS_STAT, 32'h0);
    chk(rdv & 32'h6, 32'h0);
    xfer(1'b0, `HCC_OFS_DTGT, 32'h0);
    chk(rdv, 32'h20);
    k = n_fire;
    @(posedge pclk);
    cycle_btn <= 1'b1;
    wait (die_jog === 1'b1);
    @(posedge pclk);
    cycle_btn <= 1'b0;
    repeat (4) @(posedge pclk);
    chk(n_fire, k);
    xfer(1'b0, `HCC_OFS_STAT, 32'h0);
    chk(32'(rdv[`HCC_ST_ABORT]), 32'h1);
    // clear without confirmation keeps the queue
    xfer(1'b1, `HCC_OFS_CMD, 32'h1);
    xfer(1'b0, `HCC_OFS_HPAS, 32'h0);
    chk(rdv, 32'h1);
    xfer(1'b1, `HCC_OFS_CMD, 32'h3);
    xfer(1'b0, `HCC_OFS_HPAS, 32'h0);
    chk(rdv, 32'h0);
    // length mode, zero part length: one piece then stop
    xfer(1'b1, `HCC_OFS_CTRL, 32'h0);
    xfer(1'b1, `HCC_OFS_QTY, 32'h1);
    kick();
    wait (line_run === 1'b1);
    wait (line_run === 1'b0 && press === 1'b0);
    xfer(1'b0, `HCC_OFS_TPCS, 32'h0);
    chk(rdv, 32'h6);
    tally_and_finish();
  end
endmodule
